// [src/eeprom_sector_modify_sequencer.sv]
`include "eeprom_seq_params.svh"

module eeprom_sector_modify_sequencer #(
	parameter int WORD_BITS = 5 // Array holds 2**WORD_BITS words
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Register port
	input wire eeprom_seq_pkg::bus_req_t bus_in,
	output logic [15:0] rd_data_out,
	// Interrupt
	output logic irq_out
);

	localparam int WORDS = 2 ** WORD_BITS;

	// Decoded strobes
	logic arr_wr; // Write into the array window
	logic arr_rd; // Read from the array window
	logic wr_div;
	logic wr_stat;
	logic wr_cmd;
	logic wr_prot;
	logic wr_mask;
	logic rd_stat;
	logic rd_irq;

	// Register state
	logic [6:0] div_r; // Timing clock divider
	logic divld_r; // Divider written since reset
	logic [7:0] prot_r; // Enable and lowest protected sector
	logic command_buffer_empty_flag_r; // Command buffer empty
	logic command_complete_flag_r; // Command complete
	logic protection_violation_flag_r; // Protection violation
	logic access_error_flag_r; // Access error
	logic [2:0] irq_stat_r; // Sticky event bits
	logic [2:0] irq_mask_r; // Event enables

	// Sequencer state
	eeprom_seq_pkg::seq_state_t seq_r;
	eeprom_seq_pkg::exe_state_t exe_r;
	eeprom_seq_pkg::cmd_buf_t buf_r; // Command being loaded
	eeprom_seq_pkg::cmd_buf_t run_r; // Command being executed
	logic [7:0] cnt_r; // Timing ticks left in phase
	logic [15:0] mem_r [WORDS]; // Array storage

	// Derived conditions
	logic tick;
	logic arr_ok;
	logic cmd_ok;
	logic launch_try;
	logic prot_hit;
	logic launch_ok;
	logic take;
	logic erase_end;
	logic done_evt;
	logic access_error_flag_evt;
	logic protection_violation_flag_evt;

	// Word index from a byte address, low bit dropped
	function automatic logic [WORD_BITS-1:0] word_of(input logic [7:0] a);
		word_of = a[WORD_BITS:1];
	endfunction

	// Sector lies at or above the enabled protection bound
	function automatic logic is_protected(input logic [5:0] w,
		input logic [7:0] p);
		is_protected = p[`PROT_EN_BIT] &&
			({3'b000, w[5:1]} >= {1'b0, p[6:0]});
	endfunction

	// Access decode
	always_comb begin
		arr_wr = bus_in.wr && bus_in.addr[`ARRAY_SEL_BIT];
		arr_rd = bus_in.rd && bus_in.addr[`ARRAY_SEL_BIT];
		wr_div = bus_in.wr && (bus_in.addr == `OFS_DIV);
		wr_stat = bus_in.wr && (bus_in.addr == `OFS_STAT);
		wr_cmd = bus_in.wr && (bus_in.addr == `OFS_CMD);
		wr_prot = bus_in.wr && (bus_in.addr == `OFS_PROT);
		wr_mask = bus_in.wr && (bus_in.addr == `OFS_IRQ_MASK);
		rd_stat = bus_in.rd && (bus_in.addr == `OFS_STAT);
		rd_irq = bus_in.rd && (bus_in.addr == `OFS_IRQ_STAT);
	end

	// Sequence checks and events
	always_comb begin
		arr_ok = arr_wr && (seq_r == eeprom_seq_pkg::SEQ_IDLE) && command_buffer_empty_flag_r;
		cmd_ok = wr_cmd && (seq_r == eeprom_seq_pkg::SEQ_ADDR) &&
			(bus_in.wdata[7:0] == `CMD_SECT_MOD);
		launch_try = wr_stat && bus_in.wdata[`ST_COMMAND_BUFFER_EMPTY_FLAG];
		prot_hit = is_protected(buf_r.word, prot_r);
		launch_ok = launch_try && (seq_r == eeprom_seq_pkg::SEQ_CMD) &&
			divld_r && !prot_hit;
		take = !command_buffer_empty_flag_r && (exe_r == eeprom_seq_pkg::EXE_IDLE);
		erase_end = (exe_r == eeprom_seq_pkg::EXE_ERASE) && tick &&
			(cnt_r == 8'h01);
		done_evt = (exe_r == eeprom_seq_pkg::EXE_PROG) && tick &&
			(cnt_r == 8'h01);
		// Out-of-order steps and a missing divider are access errors
		access_error_flag_evt = (arr_wr && !arr_ok) || (wr_cmd && !cmd_ok) ||
			(launch_try && ((seq_r != eeprom_seq_pkg::SEQ_CMD) ||
			!divld_r));
		protection_violation_flag_evt = launch_try && (seq_r == eeprom_seq_pkg::SEQ_CMD) &&
			divld_r && prot_hit;
	end

	// Timing clock derived from the bus clock
	eeprom_timing_clock u_timing (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.div_in(div_r),
		.run_in(divld_r),
		.tick_out(tick)
	);

	// Divider and its loaded flag
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			div_r <= `DIV_RST;
			divld_r <= 1'b0;
		end else if (wr_div) begin
			div_r <= bus_in.wdata[6:0];
			divld_r <= 1'b1;
		end
	end

	// Protection bound
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			prot_r <= `PROT_RST;
		end else if (wr_prot) begin
			prot_r <= bus_in.wdata[7:0];
		end
	end

	// Command write sequence; any error returns to idle
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			seq_r <= eeprom_seq_pkg::SEQ_IDLE;
			buf_r <= '0;
		end else if (arr_ok) begin
			seq_r <= eeprom_seq_pkg::SEQ_ADDR;
			buf_r.word <= 6'(word_of(bus_in.addr));
			buf_r.data <= bus_in.wdata;
		end else if (cmd_ok) begin
			seq_r <= eeprom_seq_pkg::SEQ_CMD;
			buf_r.cmd <= bus_in.wdata[7:0];
		end else if (access_error_flag_evt || protection_violation_flag_evt || launch_ok) begin
			seq_r <= eeprom_seq_pkg::SEQ_IDLE;
		end
	end

	// Buffer empty flag: launch clears, take sets
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			command_buffer_empty_flag_r <= 1'b1;
		end else if (launch_ok) begin
			command_buffer_empty_flag_r <= 1'b0;
		end else if (take) begin
			command_buffer_empty_flag_r <= 1'b1;
		end
	end

	// Complete flag: low while running, set at end if nothing waits
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			command_complete_flag_r <= 1'b1;
		end else if (take) begin
			command_complete_flag_r <= 1'b0;
		end else if (done_evt && command_buffer_empty_flag_r) begin
			command_complete_flag_r <= 1'b1;
		end
	end

	// Error flags: write 1 clears, a new event wins
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			access_error_flag_r <= 1'b0;
			protection_violation_flag_r <= 1'b0;
		end else begin
			if (access_error_flag_evt) begin
				access_error_flag_r <= 1'b1;
			end else if (wr_stat && bus_in.wdata[`ST_ACCESS_ERROR_FLAG]) begin
				access_error_flag_r <= 1'b0;
			end
			if (protection_violation_flag_evt) begin
				protection_violation_flag_r <= 1'b1;
			end else if (wr_stat && bus_in.wdata[`ST_PROTECTION_VIOLATION_FLAG]) begin
				protection_violation_flag_r <= 1'b0;
			end
		end
	end

	// Embedded algorithm: erase phase then program phase
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			exe_r <= eeprom_seq_pkg::EXE_IDLE;
			cnt_r <= 8'h00;
			run_r <= '0;
		end else begin
			unique case (exe_r)
				eeprom_seq_pkg::EXE_IDLE: begin
					if (take) begin
						run_r <= buf_r;
						cnt_r <= `ERASE_TICKS;
						exe_r <= eeprom_seq_pkg::EXE_ERASE;
					end
				end
				eeprom_seq_pkg::EXE_ERASE: begin
					// Phase length counts timing ticks only
					if (erase_end) begin
						cnt_r <= `PROG_TICKS;
						exe_r <= eeprom_seq_pkg::EXE_PROG;
					end else if (tick) begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				eeprom_seq_pkg::EXE_PROG: begin
					if (done_evt) begin
						exe_r <= eeprom_seq_pkg::EXE_IDLE;
					end else if (tick) begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: begin
					exe_r <= eeprom_seq_pkg::EXE_IDLE;
				end
			endcase
		end
	end

	// Array storage: erase both sector words, then write one
	always_ff @(posedge clk_sys_in) begin
		if (erase_end) begin
			mem_r[{run_r.word[WORD_BITS-1:1], 1'b0}] <= `ERASED_WORD;
			mem_r[{run_r.word[WORD_BITS-1:1], 1'b1}] <= `ERASED_WORD;
		end else if (done_evt) begin
			mem_r[run_r.word[WORD_BITS-1:0]] <= run_r.data;
		end
	end

	// Interrupt status: events set, a read clears, set wins
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_stat_r <= 3'h0;
		end else begin
			irq_stat_r <= (rd_irq ? 3'h0 : irq_stat_r) |
				{protection_violation_flag_evt, access_error_flag_evt, done_evt};
		end
	end

	// Interrupt mask and output
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_mask_r <= `IRQ_MASK_RST;
			irq_out <= 1'b0;
		end else begin
			if (wr_mask) begin
				irq_mask_r <= bus_in.wdata[2:0];
			end
			irq_out <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !bus_in.rd) begin
			rd_data_out <= 16'h0000;
		end else if (arr_rd) begin
			rd_data_out <= mem_r[word_of(bus_in.addr)];
		end else begin
			unique case (bus_in.addr)
				`OFS_DIV: rd_data_out <= {9'h000, div_r};
				`OFS_STAT: begin
					rd_data_out <= {8'h00, command_buffer_empty_flag_r, command_complete_flag_r, protection_violation_flag_r,
						access_error_flag_r, 3'h0, divld_r};
				end
				`OFS_CMD: rd_data_out <= {8'h00, buf_r.cmd};
				`OFS_PROT: rd_data_out <= {8'h00, prot_r};
				`OFS_IRQ_STAT: rd_data_out <= {13'h0000, irq_stat_r};
				`OFS_IRQ_MASK: rd_data_out <= {13'h0000, irq_mask_r};
				default: rd_data_out <= 16'h0000;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_div_sets_flag: assert property (
		wr_div |=> divld_r)
		else $error("divider write did not set loaded flag");

	a_flag_needs_write: assert property (
		$rose(divld_r) |-> $past(wr_div))
		else $error("loaded flag rose without divider write");

	a_no_div_refused: assert property (
		(launch_try && !divld_r) |=> (access_error_flag_r && command_buffer_empty_flag_r &&
			seq_r == eeprom_seq_pkg::SEQ_IDLE))
		else $error("launch without divider was not refused");

	a_tick_period: assert property (
		(tick && div_r == 7'h03 && !wr_div) ##1 !wr_div[*3]
			|-> (!tick && !$past(tick) && !$past(tick, 2)) ##1 tick)
		else $error("timing tick period does not follow divider");

	a_erase_both: assert property (
		erase_end |=> (mem_r[{run_r.word[WORD_BITS-1:1], 1'b0}] ==
			`ERASED_WORD) && (mem_r[{run_r.word[WORD_BITS-1:1], 1'b1}]
			== `ERASED_WORD) && exe_r == eeprom_seq_pkg::EXE_PROG)
		else $error("sector not fully erased before program");

	a_word_from_addr: assert property (
		arr_ok |=> buf_r.word == $past(bus_in.addr[WORD_BITS:1]))
		else $error("buffered word does not match address");

	a_launch_clears: assert property (
		launch_ok |=> !command_buffer_empty_flag_r ##1
			(($past(exe_r) == eeprom_seq_pkg::EXE_IDLE) ?
			(command_buffer_empty_flag_r && !command_complete_flag_r) : !command_buffer_empty_flag_r))
		else $error("launch did not clear and refill buffer flag");

	a_prot_blocks: assert property (
		protection_violation_flag_evt |=> (protection_violation_flag_r && command_buffer_empty_flag_r))
		else $error("protected sector was launched");

	a_done_sets_cc: assert property (
		(done_evt && command_buffer_empty_flag_r) |=> (command_complete_flag_r &&
			exe_r == eeprom_seq_pkg::EXE_IDLE))
		else $error("complete flag not set after finish");

	a_cc_held_buffered: assert property (
		(done_evt && !command_buffer_empty_flag_r) |=> !command_complete_flag_r)
		else $error("complete flag set with command buffered");

	a_take_refills: assert property (
		take |=> (command_buffer_empty_flag_r && exe_r == eeprom_seq_pkg::EXE_ERASE &&
			cnt_r == `ERASE_TICKS))
		else $error("buffer flag not set when command taken");

	a_irq_level: assert property (
		(|(irq_stat_r & irq_mask_r)) |=> irq_out)
		else $error("interrupt not raised for unmasked event");

endmodule // eeprom_sector_modify_sequencer

// [src/eeprom_seq_params.svh]
`ifndef EEPROM_SEQ_PARAMS_SVH
`define EEPROM_SEQ_PARAMS_SVH

// Register offsets
`define OFS_DIV 8'h00
`define OFS_STAT 8'h04
`define OFS_CMD 8'h08
`define OFS_PROT 8'h0c
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14
// Address bit that selects the array window
`define ARRAY_SEL_BIT 7

// Status register fields
`define ST_COMMAND_BUFFER_EMPTY_FLAG 7
`define ST_COMMAND_COMPLETE_FLAG 6
`define ST_PROTECTION_VIOLATION_FLAG 5
`define ST_ACCESS_ERROR_FLAG 4
`define ST_DIVLD 0

// Protection register fields
`define PROT_EN_BIT 7

// Interrupt status and mask fields
`define IRQ_DONE 0
`define IRQ_ACCESS_ERROR_FLAG 1
`define IRQ_PROTECTION_VIOLATION_FLAG 2

// Reset values
`define DIV_RST 7'h00
`define PROT_RST 8'h00
`define IRQ_MASK_RST 3'h0

// Command code and timing counts in timing clock periods
`define CMD_SECT_MOD 8'h60
`define ERASE_TICKS 8'h0a
`define PROG_TICKS 8'h05
`define ERASED_WORD 16'hffff

`endif

// [src/eeprom_seq_pkg.sv]
package eeprom_seq_pkg;

	// One bus access from the register port
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// Command write sequence progress
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ADDR = 2'b01,
		SEQ_CMD = 2'b10
	} seq_state_t;

	// Embedded algorithm phase
	typedef enum logic [1:0] {
		EXE_IDLE = 2'b00,
		EXE_ERASE = 2'b01,
		EXE_PROG = 2'b10
	} exe_state_t;

	// A buffered or running command
	typedef struct packed {
		logic [5:0] word;
		logic [15:0] data;
		logic [7:0] cmd;
	} cmd_buf_t;

endpackage

// [src/eeprom_timing_clock.sv]
`include "eeprom_seq_params.svh"

module eeprom_timing_clock (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Divider setting and run enable
	input wire logic [6:0] div_in,
	input wire logic run_in,
	// One bus-cycle pulse per timing clock period
	output logic tick_out
);

	logic [6:0] cnt_r; // Bus cycles into the current period

	// Period is div_in + 1 bus cycles; restarts when not running
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !run_in) begin
			cnt_r <= 7'h00;
			tick_out <= 1'b0;
		end else if (cnt_r >= div_in) begin
			cnt_r <= 7'h00;
			tick_out <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 7'h01;
			tick_out <= 1'b0;
		end
	end

endmodule // eeprom_timing_clock

// [verif/eeprom_sector_modify_sequencer_tb.sv]
module eeprom_sector_modify_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// Clock, reset and design ports
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	eeprom_seq_pkg::bus_req_t bus_in = '0;
	logic [15:0] rd_data_out;
	logic irq_out;
	// Result counters and scratch values
	int fail_count = 0;
	int checked = 0;
	logic [15:0] v;
	int n0;
	int n3;
	int k;

	// 250 MHz bus clock
	always #2 clk_sys_in = ~clk_sys_in;

	eeprom_sector_modify_sequencer #(.WORD_BITS(5)) i_dut (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.bus_in(bus_in),
		.rd_data_out(rd_data_out),
		.irq_out(irq_out)
	);

	// One-cycle write strobe beside address and data
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		bus_in.addr <= a;
		bus_in.wdata <= d;
		bus_in.wr <= 1'b1;
		@(posedge clk_sys_in);
		bus_in.wr <= 1'b0;
	endtask

	// One-cycle read strobe; data sampled in the following cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys_in);
		bus_in.addr <= a;
		bus_in.rd <= 1'b1;
		@(posedge clk_sys_in);
		bus_in.rd <= 1'b0;
		#1;
		d = rd_data_out;
	endtask

	// Compare and count
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// Read a place and compare it
	task automatic rchk(input logic [7:0] a, input logic [15:0] e,
		input string n);
		rd(a, v);
		chk(n, e, v);
	endtask

	// Full three-step sector modify sequence
	task automatic modify(input logic [7:0] a, input logic [15:0] d);
		wr(a, d);
		wr(8'h08, 16'h0060);
		wr(8'h04, 16'h0080);
	endtask

	// Poll the status until the complete flag shows, counting polls
	task automatic wait_done(output int n);
		n = 0;
		repeat (2) @(posedge clk_sys_in);
		do begin
			rd(8'h04, v);
			n++;
		end while (v[6] !== 1'b1 && n < 400);
		chk("done in time", 16'h0001, {15'h0000, n < 400});
	endtask

	// Print the counts and the verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		fail_count++;
		$display("wrong value watchdog expected end seen hang");
		give_verdict();
	end

	// Main test sequence
	initial begin
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// Reset values
		rchk(8'h04, 16'h00c0, "status after reset");
		rchk(8'h10, 16'h0000, "irq status after reset");
		rchk(8'h14, 16'h0000, "irq mask after reset");
		$display("test reset done");
		// Launch before divider written is refused
		modify(8'h84, 16'h1111);
		rchk(8'h04, 16'h00d0, "status no divider");
		rchk(8'h10, 16'h0002, "irq status access error");
		chk("irq masked", 16'h0000, {15'h0000, irq_out});
		wr(8'h04, 16'h0010);
		$display("test no divider done");
		// Divider write sets the loaded flag
		wr(8'h00, 16'h0000);
		rchk(8'h04, 16'h00c1, "status divider loaded");
		$display("test divider done");
		// Odd byte address selects the same word; sector fully erased
		modify(8'h85, 16'ha5a5);
		wait_done(n0);
		rchk(8'h84, 16'ha5a5, "word 2");
		rchk(8'h86, 16'hffff, "word 3 erased");
		modify(8'h86, 16'h5a5a);
		wait_done(n0);
		rchk(8'h84, 16'hffff, "word 2 erased");
		rchk(8'h86, 16'h5a5a, "word 3");
		rchk(8'h04, 16'h00c1, "status after done");
		$display("test sector modify done");
		// Divider 3 stretches 15 ticks by 3 extra cycles each
		// Ticks are scaled short to keep the run brief; a real part
		// needs a much slower timing step than this bench uses
		wr(8'h00, 16'h0003);
		modify(8'h86, 16'h1357);
		wait_done(n3);
		k = (n3 - n0) * 2;
		chk("duration growth", 16'h0001,
			{15'h0000, k >= 41 && k <= 49});
		wr(8'h00, 16'h0000);
		$display("test timing done");
		// Sector 1 protected: violation, array kept
		wr(8'h0c, 16'h0081);
		modify(8'h84, 16'h2222);
		rchk(8'h04, 16'h00e1, "status protected");
		rchk(8'h84, 16'hffff, "protected word");
		wr(8'h04, 16'h0020);
		wr(8'h0c, 16'h0000);
		rchk(8'h04, 16'h00c1, "violation cleared");
		$display("test protection done");
		// Second sequence buffered while the first runs
		wr(8'h14, 16'h0001);
		rd(8'h10, v);
		modify(8'h80, 16'h0f0f);
		repeat (2) @(posedge clk_sys_in);
		modify(8'h82, 16'hf0f0);
		k = 0;
		while (irq_out !== 1'b1 && k < 200) begin
			@(posedge clk_sys_in);
			#1;
			k++;
		end
		chk("irq seen", 16'h0001, {15'h0000, k < 200});
		rd(8'h04, v);
		chk("complete flag held", 16'h0000, {15'h0000, v[6]});
		rchk(8'h10, 16'h0001, "irq status first done");
		wait_done(n0);
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk("irq raised", 16'h0001, {15'h0000, irq_out});
		rchk(8'h10, 16'h0001, "irq status second done");
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk("irq cleared", 16'h0000, {15'h0000, irq_out});
		rchk(8'h80, 16'hffff, "word 0 erased");
		rchk(8'h82, 16'hf0f0, "word 1");
		rchk(8'h18, 16'h0000, "unmapped read");
		$display("test buffered command done");
		give_verdict();
	end

endmodule // eeprom_sector_modify_sequencer_tb
